//--- design/servo_limit_pkg.sv
package servo_limit_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int AIN_W  = 18;
  localparam int ST_W   = 3;

  typedef logic signed [19:0] speed_t;

  typedef struct packed {
    speed_t pos;
    speed_t neg;
  } limit_pair_t;

  typedef struct packed {
    logic sel1;
    logic sel0;
    logic inhibit;
    logic servo_on;
    logic supply_ok;
  } pins_t;

  typedef enum logic [1:0] {
    DRV_OFF,
    DRV_READY,
    DRV_SUSPENDED
  } drive_state_t;

  // Register byte offsets.
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_STATUS    = 8'h04;
  localparam logic [7:0] ADDR_MASK      = 8'h08;
  localparam logic [7:0] ADDR_HYST      = 8'h0c;
  localparam logic [7:0] ADDR_OVR_POS   = 8'h10;
  localparam logic [7:0] ADDR_OVR_NEG   = 8'h14;
  localparam logic [7:0] ADDR_INT_POS0  = 8'h18;
  localparam logic [7:0] ADDR_INT_NEG0  = 8'h24;
  localparam logic [7:0] ADDR_SCALE     = 8'h30;
  localparam logic [7:0] ADDR_OFFSET    = 8'h34;
  localparam logic [7:0] ADDR_STATE     = 8'h38;
  localparam logic [7:0] ADDR_ACT_POS   = 8'h3c;
  localparam logic [7:0] ADDR_ACT_NEG   = 8'h40;
  localparam logic [7:0] ADDR_STEP      = 8'h04;

  // Field positions.
  localparam int CTRL_PULSE_BIT    = 0;
  localparam int CTRL_COMPOUND_BIT = 1;
  localparam int ST_FAULT_BIT      = 0;
  localparam int ST_ALARM_BIT      = 1;
  localparam int ST_LOAD_BIT       = 2;

  // Limit source codes, sel1:sel0.
  localparam logic [1:0] SEL_INT1 = 2'h0;
  localparam logic [1:0] SEL_EXT  = 2'h1;
  localparam logic [1:0] SEL_INT2 = 2'h2;
  localparam logic [1:0] SEL_INT3 = 2'h3;

  // Ranges and reset values, rpm or units of 0.1 mV.
  localparam speed_t SPEED_MAX    = 20'sh33450;
  localparam speed_t SPEED_MIN    = -20'sh33450;
  localparam speed_t SCALE_MIN    = 20'sh00006;
  localparam speed_t SCALE_RESET  = 20'sh00bb8;
  localparam speed_t OFFSET_MAX   = 20'sh01388;
  localparam speed_t OFFSET_MIN   = -20'sh01388;
  localparam speed_t OFFSET_RESET = 20'sh00000;
  localparam speed_t HYST_RESET   = 20'sh00000;
  localparam speed_t ZERO_SPEED   = 20'sh00000;
  localparam logic [40:0] FULL_SCALE = 41'h000000186a0;

endpackage

//--- design/pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int W = 5
) (
  input  wire logic         clk,    // Core clock.
  input  wire logic         srst,   // Synchronous reset.
  input  wire logic [W-1:0] d,      // Asynchronous pin levels.
  output var  logic [W-1:0] q       // Synchronised levels.
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule
`default_nettype wire

//--- design/ext_limit_scale.sv
`timescale 1ns/100ps
`default_nettype none
module ext_limit_scale (
  input  wire logic                    clk,      // Core clock.
  input  wire logic                    srst,     // Synchronous reset.
  input  wire logic signed [17:0]      ain,      // Analog level, 0.1 mV.
  input  wire servo_limit_pkg::speed_t offset,   // Offset, 0.1 mV.
  input  wire servo_limit_pkg::speed_t scaling,  // Rpm at 10 V.
  output var  servo_limit_pkg::speed_t limit_q   // External limit, rpm.
);

  logic signed [20:0] sum;
  logic [40:0]        prod;
  logic [40:0]        quo;

  // A negative corrected level gives a zero limit rather than a flipped one.
  always_comb begin
    sum  = 21'(ain) + 21'(offset);
    prod = sum[20] ? '0 : 41'(sum[19:0]) * 41'(scaling[19:0]);
    quo  = prod / servo_limit_pkg::FULL_SCALE;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      limit_q <= servo_limit_pkg::ZERO_SPEED;
    end else if (quo > 41'(servo_limit_pkg::SPEED_MAX)) begin
      limit_q <= servo_limit_pkg::SPEED_MAX;
    end else begin
      limit_q <= servo_limit_pkg::speed_t'(quo[19:0]);
    end
  end

  neg_level_a: assert property (@(posedge clk) disable iff (srst)
    sum[20] |=> limit_q == servo_limit_pkg::ZERO_SPEED)
    else $error("negative level did not give zero limit");

  scale_range_a: assert property (@(posedge clk) disable iff (srst)
    !$past(srst) |-> limit_q >= servo_limit_pkg::ZERO_SPEED &&
                     limit_q <= servo_limit_pkg::SPEED_MAX)
    else $error("external limit out of range");

endmodule
`default_nettype wire

//--- design/servo_speed_limit_select.sv
// Function
// - Inhibit high blocks pulse setpoint, low passes.
// - Inhibit honoured only while servo-on is off.
// - Active inhibit in pulse modes raises alarm.
// - Select inputs choose one of four limits.
// - Selection works always, also while running.
// - Fault when speed leaves limit plus hysteresis.
// - Overall limit bounds, reset to extremes.
// - Three internal limit pairs, reset to extremes.
// - Commissioning loads motor maximum into limits.
// - Analog 10 V equals scaling setting.
// - Programmable offset added to analog input.
// - External limit resumes after supply return.
// - Servo-on rise powers up, fall coasts.
`timescale 1ns/100ps
`default_nettype none
module servo_speed_limit_select (
  input  wire logic                    CORE_CLK,         // 50 MHz clock.
  input  wire logic                    SRST,             // Sync reset.
  input  wire logic [7:0]              ADDR,             // Byte address.
  input  wire logic [31:0]             WDATA,            // Write data.
  input  wire logic                    WR,               // Write strobe.
  input  wire logic                    RD,               // Read strobe.
  output var  logic [31:0]             RDATA,            // Read data.
  input  wire logic                    PULSE_INHIBIT_IN, // Inhibit pin.
  input  wire logic                    SERVO_ON_IN,      // Servo-on pin.
  input  wire logic                    SPEED_LIMIT_SEL0, // Select pin 0.
  input  wire logic                    SPEED_LIMIT_SEL1, // Select pin 1.
  input  wire logic                    SUPPLY_OK_IN,     // Control supply.
  input  wire logic                    COMMISSION_DONE,  // One-cycle pulse.
  input  wire servo_limit_pkg::speed_t MOTOR_MAX_SPEED,  // Motor max, rpm.
  input  wire servo_limit_pkg::speed_t SPEED_SETPOINT,   // Raw setpoint.
  input  wire servo_limit_pkg::speed_t ACTUAL_SPEED,     // Measured speed.
  input  wire logic signed [17:0]      AIN1_LEVEL,       // Analog, 0.1 mV.
  output var  servo_limit_pkg::speed_t SPEED_CMD,        // Clamped setpoint.
  output var  logic                    PULSE_ENABLE,     // Pulses accepted.
  output var  logic                    POWER_ON,         // Power circuit.
  output var  logic                    INHIBIT_ALARM,    // Inhibit alarm.
  output var  logic                    SPEED_FAULT,      // Overspeed fault.
  output var  logic                    IRQ               // Interrupt.
);

  servo_limit_pkg::pins_t       pins;
  servo_limit_pkg::drive_state_t drive_q;
  servo_limit_pkg::speed_t      hyst_q;
  servo_limit_pkg::speed_t      scale_q;
  servo_limit_pkg::speed_t      offset_q;
  servo_limit_pkg::speed_t      ext_lim;
  servo_limit_pkg::speed_t      int_pos_q [3];
  servo_limit_pkg::speed_t      int_neg_q [3];
  servo_limit_pkg::limit_pair_t overall_q;
  servo_limit_pkg::limit_pair_t src_mux;
  servo_limit_pkg::limit_pair_t src_lim_q;
  servo_limit_pkg::limit_pair_t act_lim_q;
  logic [1:0]                   ctrl_q;
  logic [2:0]                   status_q;
  logic [2:0]                   status_set;
  logic [2:0]                   mask_q;
  logic                         son_prev_q;
  logic                         son_rise;
  logic                         son_fall;
  logic                         inhibit_eff;
  logic                         fault_cond;
  logic signed [20:0]           hi_bound;
  logic signed [20:0]           lo_bound;
  logic [31:0]                  rd_d;

  // Keeps a value inside a closed range, used for writes and the setpoint.
  function automatic servo_limit_pkg::speed_t fit(
    input logic signed [31:0]      v,
    input servo_limit_pkg::speed_t lo,
    input servo_limit_pkg::speed_t hi
  );
    if (v < 32'(lo)) begin
      return lo;
    end else if (v > 32'(hi)) begin
      return hi;
    end
    return servo_limit_pkg::speed_t'(v[19:0]);
  endfunction

  pin_sync #(
    .W (5)
  ) u_sync (
    .clk  (CORE_CLK),
    .srst (SRST),
    .d    ({SPEED_LIMIT_SEL1, SPEED_LIMIT_SEL0, PULSE_INHIBIT_IN,
            SERVO_ON_IN, SUPPLY_OK_IN}),
    .q    (pins)
  );

  ext_limit_scale u_scale (
    .clk     (CORE_CLK),
    .srst    (SRST),
    .ain     (AIN1_LEVEL),
    .offset  (offset_q),
    .scaling (scale_q),
    .limit_q (ext_lim)
  );

  assign son_rise    = pins.servo_on & ~son_prev_q;
  assign son_fall    = ~pins.servo_on & son_prev_q;
  assign inhibit_eff = pins.inhibit & ~pins.servo_on;

  // Drive sequencing. A supply loss while the external limit is selected
  // parks the drive so that it restarts without a new servo-on edge.
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      son_prev_q <= 1'b0;
      drive_q    <= servo_limit_pkg::DRV_OFF;
    end else begin
      son_prev_q <= pins.servo_on;
      case (drive_q)
        servo_limit_pkg::DRV_OFF: begin
          if (son_rise && pins.supply_ok) begin
            drive_q <= servo_limit_pkg::DRV_READY;
          end
        end
        servo_limit_pkg::DRV_READY: begin
          if (!pins.supply_ok) begin
            drive_q <= ({pins.sel1, pins.sel0} == servo_limit_pkg::SEL_EXT)
                       ? servo_limit_pkg::DRV_SUSPENDED
                       : servo_limit_pkg::DRV_OFF;
          end else if (son_fall) begin
            drive_q <= servo_limit_pkg::DRV_OFF;
          end
        end
        servo_limit_pkg::DRV_SUSPENDED: begin
          if (!pins.servo_on) begin
            drive_q <= servo_limit_pkg::DRV_OFF;
          end else if (pins.supply_ok) begin
            drive_q <= servo_limit_pkg::DRV_READY;
          end
        end
        default: drive_q <= servo_limit_pkg::DRV_OFF;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      POWER_ON      <= 1'b0;
      PULSE_ENABLE  <= 1'b0;
      INHIBIT_ALARM <= 1'b0;
    end else begin
      POWER_ON      <= (drive_q == servo_limit_pkg::DRV_READY);
      PULSE_ENABLE  <= ctrl_q[servo_limit_pkg::CTRL_PULSE_BIT] &&
                       (drive_q == servo_limit_pkg::DRV_READY) &&
                       !inhibit_eff;
      INHIBIT_ALARM <= (ctrl_q[servo_limit_pkg::CTRL_PULSE_BIT] ||
                        ctrl_q[servo_limit_pkg::CTRL_COMPOUND_BIT]) &&
                       inhibit_eff;
    end
  end

  // Source selection is not gated by mode or drive state.
  always_comb begin
    case ({pins.sel1, pins.sel0})
      servo_limit_pkg::SEL_INT1: src_mux = '{int_pos_q[0], int_neg_q[0]};
      servo_limit_pkg::SEL_EXT:  src_mux = '{ext_lim, -ext_lim};
      servo_limit_pkg::SEL_INT2: src_mux = '{int_pos_q[1], int_neg_q[1]};
      servo_limit_pkg::SEL_INT3: src_mux = '{int_pos_q[2], int_neg_q[2]};
      default:                   src_mux = '{int_pos_q[0], int_neg_q[0]};
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      src_lim_q <= '{servo_limit_pkg::SPEED_MAX, servo_limit_pkg::SPEED_MIN};
      act_lim_q <= '{servo_limit_pkg::SPEED_MAX, servo_limit_pkg::SPEED_MIN};
      SPEED_CMD <= servo_limit_pkg::ZERO_SPEED;
    end else begin
      src_lim_q     <= src_mux;
      act_lim_q.pos <= (src_lim_q.pos < overall_q.pos) ? src_lim_q.pos
                       : overall_q.pos;
      act_lim_q.neg <= (src_lim_q.neg > overall_q.neg) ? src_lim_q.neg
                       : overall_q.neg;
      SPEED_CMD     <= fit(32'(SPEED_SETPOINT), act_lim_q.neg,
                           act_lim_q.pos);
    end
  end

  assign hi_bound   = 21'(act_lim_q.pos) + 21'(hyst_q);
  assign lo_bound   = 21'(act_lim_q.neg) - 21'(hyst_q);
  assign fault_cond = (21'(ACTUAL_SPEED) > hi_bound) ||
                      (21'(ACTUAL_SPEED) < lo_bound);

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      SPEED_FAULT <= 1'b0;
      IRQ         <= 1'b0;
    end else begin
      SPEED_FAULT <= fault_cond;
      IRQ         <= |(status_q & mask_q);
    end
  end

  // Parameter registers. Commissioning wins over a write in the same cycle
  // because the motor maximum must not be lost.
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      overall_q <= '{servo_limit_pkg::SPEED_MAX, servo_limit_pkg::SPEED_MIN};
      int_pos_q <= '{default: servo_limit_pkg::SPEED_MAX};
      int_neg_q <= '{default: servo_limit_pkg::SPEED_MIN};
    end else if (COMMISSION_DONE) begin
      overall_q <= '{MOTOR_MAX_SPEED, -MOTOR_MAX_SPEED};
      int_pos_q <= '{default: MOTOR_MAX_SPEED};
      int_neg_q <= '{default: -MOTOR_MAX_SPEED};
    end else if (WR) begin
      if (ADDR == servo_limit_pkg::ADDR_OVR_POS) begin
        overall_q.pos <= fit(WDATA, servo_limit_pkg::ZERO_SPEED,
                             servo_limit_pkg::SPEED_MAX);
      end
      if (ADDR == servo_limit_pkg::ADDR_OVR_NEG) begin
        overall_q.neg <= fit(WDATA, servo_limit_pkg::SPEED_MIN,
                             servo_limit_pkg::ZERO_SPEED);
      end
      for (int i = 0; i < 3; i++) begin
        if (ADDR == servo_limit_pkg::ADDR_INT_POS0 +
                    8'(i) * servo_limit_pkg::ADDR_STEP) begin
          int_pos_q[i] <= fit(WDATA, servo_limit_pkg::ZERO_SPEED,
                              servo_limit_pkg::SPEED_MAX);
        end
        if (ADDR == servo_limit_pkg::ADDR_INT_NEG0 +
                    8'(i) * servo_limit_pkg::ADDR_STEP) begin
          int_neg_q[i] <= fit(WDATA, servo_limit_pkg::SPEED_MIN,
                              servo_limit_pkg::ZERO_SPEED);
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      ctrl_q   <= 2'h0;
      mask_q   <= 3'h0;
      hyst_q   <= servo_limit_pkg::HYST_RESET;
      scale_q  <= servo_limit_pkg::SCALE_RESET;
      offset_q <= servo_limit_pkg::OFFSET_RESET;
    end else if (WR) begin
      case (ADDR)
        servo_limit_pkg::ADDR_CTRL: ctrl_q <= WDATA[1:0];
        servo_limit_pkg::ADDR_MASK: mask_q <= WDATA[2:0];
        servo_limit_pkg::ADDR_HYST: hyst_q <= fit(WDATA,
          servo_limit_pkg::ZERO_SPEED, servo_limit_pkg::SPEED_MAX);
        servo_limit_pkg::ADDR_SCALE: scale_q <= fit(WDATA,
          servo_limit_pkg::SCALE_MIN, servo_limit_pkg::SPEED_MAX);
        servo_limit_pkg::ADDR_OFFSET: offset_q <= fit(WDATA,
          servo_limit_pkg::OFFSET_MIN, servo_limit_pkg::OFFSET_MAX);
        default: ;
      endcase
    end
  end

  // Sticky events; a set in the clearing cycle survives the clear.
  assign status_set = {COMMISSION_DONE, INHIBIT_ALARM, SPEED_FAULT};

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      status_q <= 3'h0;
    end else if (WR && ADDR == servo_limit_pkg::ADDR_STATUS) begin
      status_q <= (status_q & ~WDATA[2:0]) | status_set;
    end else begin
      status_q <= status_q | status_set;
    end
  end

  always_comb begin
    rd_d = 32'h0;
    case (ADDR)
      servo_limit_pkg::ADDR_CTRL:    rd_d = {30'h0, ctrl_q};
      servo_limit_pkg::ADDR_STATUS:  rd_d = {29'h0, status_q};
      servo_limit_pkg::ADDR_MASK:    rd_d = {29'h0, mask_q};
      servo_limit_pkg::ADDR_HYST:    rd_d = 32'(hyst_q);
      servo_limit_pkg::ADDR_OVR_POS: rd_d = 32'(overall_q.pos);
      servo_limit_pkg::ADDR_OVR_NEG: rd_d = 32'(overall_q.neg);
      servo_limit_pkg::ADDR_SCALE:   rd_d = 32'(scale_q);
      servo_limit_pkg::ADDR_OFFSET:  rd_d = 32'(offset_q);
      servo_limit_pkg::ADDR_STATE:   rd_d = {25'h0, pins.sel1, pins.sel0,
                                             pins.servo_on, pins.inhibit,
                                             pins.supply_ok, drive_q};
      servo_limit_pkg::ADDR_ACT_POS: rd_d = 32'(act_lim_q.pos);
      servo_limit_pkg::ADDR_ACT_NEG: rd_d = 32'(act_lim_q.neg);
      default: begin
        for (int i = 0; i < 3; i++) begin
          if (ADDR == servo_limit_pkg::ADDR_INT_POS0 +
                      8'(i) * servo_limit_pkg::ADDR_STEP) begin
            rd_d = 32'(int_pos_q[i]);
          end
          if (ADDR == servo_limit_pkg::ADDR_INT_NEG0 +
                      8'(i) * servo_limit_pkg::ADDR_STEP) begin
            rd_d = 32'(int_neg_q[i]);
          end
        end
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      RDATA <= 32'h0;
    end else begin
      RDATA <= RD ? rd_d : 32'h0;
    end
  end

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (SRST);

  pulse_gate_a: assert property (
    inhibit_eff |=> !PULSE_ENABLE)
    else $error("pulse setpoint passed while inhibited");
  inhibit_son_a: assert property (
    pins.servo_on |=> !INHIBIT_ALARM)
    else $error("inhibit honoured while servo on");
  alarm_raise_a: assert property (
    ctrl_q[servo_limit_pkg::CTRL_COMPOUND_BIT] && inhibit_eff
    |=> INHIBIT_ALARM ##1 status_q[servo_limit_pkg::ST_ALARM_BIT])
    else $error("inhibit alarm not raised");
  select_int2_a: assert property (
    {pins.sel1, pins.sel0} == servo_limit_pkg::SEL_INT2
    |=> src_lim_q.pos == $past(int_pos_q[1]))
    else $error("wrong limit source for code two");
  run_switch_a: assert property (
    drive_q == servo_limit_pkg::DRV_READY &&
    {pins.sel1, pins.sel0} == servo_limit_pkg::SEL_EXT
    |=> src_lim_q.neg == -$past(ext_lim))
    else $error("source switch ignored while running");
  overspeed_a: assert property (
    fault_cond |=> SPEED_FAULT ##1 status_q[servo_limit_pkg::ST_FAULT_BIT])
    else $error("overspeed fault missing");
  overall_bound_a: assert property (
    !$past(SRST) |-> act_lim_q.pos <= $past(overall_q.pos) &&
                     act_lim_q.neg >= $past(overall_q.neg))
    else $error("overall limit exceeded");
  reset_default_a: assert property (
    $past(SRST) |-> int_pos_q[2] == servo_limit_pkg::SPEED_MAX &&
                    int_neg_q[2] == servo_limit_pkg::SPEED_MIN &&
                    overall_q.neg == servo_limit_pkg::SPEED_MIN)
    else $error("limit reset value wrong");
  commission_load_a: assert property (
    COMMISSION_DONE |=> overall_q.pos == $past(MOTOR_MAX_SPEED) &&
                        int_neg_q[0] == -$past(MOTOR_MAX_SPEED))
    else $error("motor maximum not loaded");
  supply_resume_a: assert property (
    drive_q == servo_limit_pkg::DRV_SUSPENDED && pins.supply_ok &&
    pins.servo_on |=> ##1 POWER_ON)
    else $error("no automatic resume after supply return");
  setpoint_clamp_a: assert property (
    !$past(SRST) |-> SPEED_CMD <= $past(act_lim_q.pos) &&
                     SPEED_CMD >= $past(act_lim_q.neg))
    else $error("setpoint outside enforced limit");
  servo_edge_a: assert property (
    drive_q == servo_limit_pkg::DRV_READY && son_fall && pins.supply_ok
    |=> ##1 !POWER_ON)
    else $error("falling servo-on did not coast");

  alarm_seen_c: cover property (INHIBIT_ALARM && !PULSE_ENABLE);
  fault_seen_c: cover property (SPEED_FAULT && IRQ);
  resume_seen_c: cover property (
    drive_q == servo_limit_pkg::DRV_SUSPENDED ##1
    drive_q == servo_limit_pkg::DRV_READY);

endmodule
`default_nettype wire

//--- verification/host_pin_driver.sv
`timescale 1ns/100ps
`default_nettype none
module host_pin_driver (
  input  wire logic                   clk,   // Core clock.
  input  wire servo_limit_pkg::pins_t want,  // Levels the bench asks for.
  output var  servo_limit_pkg::pins_t pins   // Levels on the drive pins.
);
  // Gear ratio is worked out in host software from encoder counts.
  localparam int ENC_COUNTS = 10000;
  // Pins move just after an edge, as a controller output would.
  always @(posedge clk) begin
    pins <= want;
  end
endmodule
`default_nettype wire

//--- verification/servo_speed_limit_select_test.sv
`timescale 1ns/100ps
`default_nettype none
module servo_speed_limit_select_test;
  logic                    clk = 1'b0;
  logic                    srst = 1'b1;
  logic [7:0]              addr = 8'h00;
  logic [31:0]             wdata = 32'h0;
  logic                    wr = 1'b0;
  logic                    rd = 1'b0;
  logic                    cdone = 1'b0;
  servo_limit_pkg::speed_t mmax = 20'sh0;
  servo_limit_pkg::speed_t setp = 20'sh0;
  servo_limit_pkg::speed_t act = 20'sh0;
  logic signed [17:0]      ain = 18'sh0;
  servo_limit_pkg::pins_t  want = 5'h01;
  servo_limit_pkg::pins_t  pins;
  servo_limit_pkg::speed_t cmd;
  logic [31:0]             rdata;
  logic                    pe, pwr, alm, flt, irq;
  int                      fails = 0;
  int                      tests_run = 0;

  always #10 clk = ~clk;

  host_pin_driver host_pin_driver_inst (.clk(clk), .want(want), .pins(pins));
  servo_speed_limit_select servo_speed_limit_select_inst (
    .CORE_CLK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .PULSE_INHIBIT_IN(pins.inhibit),
    .SERVO_ON_IN(pins.servo_on), .SPEED_LIMIT_SEL0(pins.sel0),
    .SPEED_LIMIT_SEL1(pins.sel1), .SUPPLY_OK_IN(pins.supply_ok),
    .COMMISSION_DONE(cdone), .MOTOR_MAX_SPEED(mmax), .SPEED_SETPOINT(setp),
    .ACTUAL_SPEED(act), .AIN1_LEVEL(ain), .SPEED_CMD(cmd),
    .PULSE_ENABLE(pe), .POWER_ON(pwr), .INHIBIT_ALARM(alm),
    .SPEED_FAULT(flt), .IRQ(irq));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, exp);
  endtask
  // Waits well past the two-flop pin sync and the limit pipeline.
  task automatic pins_to(input logic [4:0] p);
    @(posedge clk);
    want <= p;
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic act_to(input servo_limit_pkg::speed_t v);
    @(posedge clk);
    act <= v;
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic test_done;
    if (fails == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic t_reset;
    rd_chk(servo_limit_pkg::ADDR_OVR_POS, 32'sh33450);
    rd_chk(servo_limit_pkg::ADDR_OVR_NEG, -32'sh33450);
    for (int i = 0; i < 3; i++) begin
      rd_chk(8'h18 + 8'(4 * i), 32'sh33450);
      rd_chk(8'h24 + 8'(4 * i), -32'sh33450);
    end
    rd_chk(servo_limit_pkg::ADDR_SCALE, 32'h00000bb8);
    rd_chk(servo_limit_pkg::ADDR_OFFSET, 32'h0);
    rd_chk(8'h80, 32'h0);
  endtask
  task automatic t_select;
    logic [31:0] lim [4];
    lim = '{32'h3e8, 32'h5dc, 32'h7d0, 32'hbb8};
    @(posedge clk);
    ain <= 18'sh0c350;
    setp <= 20'sh30d40;
    wr_reg(8'h18, 32'h3e8);
    wr_reg(8'h1c, 32'h7d0);
    wr_reg(8'h20, 32'hbb8);
    for (int c = 0; c < 4; c++) begin
      pins_to({c[1], c[0], 3'h1});
      chk(32'(cmd), lim[c]);
      rd_chk(servo_limit_pkg::ADDR_ACT_POS, lim[c]);
    end
    wr_reg(servo_limit_pkg::ADDR_OFFSET, 32'h1388);
    pins_to(5'h09);
    chk(32'(cmd), 32'h672);
    rd_chk(servo_limit_pkg::ADDR_ACT_NEG, -32'sh672);
    wr_reg(servo_limit_pkg::ADDR_OFFSET, 32'h1770);
    rd_chk(servo_limit_pkg::ADDR_OFFSET, 32'h1388);
  endtask
  task automatic t_fault;
    pins_to(5'h01);
    wr_reg(servo_limit_pkg::ADDR_HYST, 32'h64);
    act_to(20'sh0044c);
    chk({31'h0, flt}, 32'h0);
    act_to(20'sh0044d);
    chk({31'h0, flt}, 32'h1);
    rd_chk(servo_limit_pkg::ADDR_STATUS, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr_reg(servo_limit_pkg::ADDR_MASK, 32'h1);
    act_to(-20'sh334b4);
    chk({30'h0, irq, flt}, 32'h2);
    wr_reg(servo_limit_pkg::ADDR_STATUS, 32'h7);
    act_to(-20'sh334b5);
    chk({31'h0, flt}, 32'h1);
    act_to(20'sh0);
    wr_reg(servo_limit_pkg::ADDR_STATUS, 32'h7);
    act_to(20'sh0);
    chk({31'h0, irq}, 32'h0);
  endtask
  task automatic t_servo;
    wr_reg(servo_limit_pkg::ADDR_CTRL, 32'h1);
    pins_to(5'h03);
    chk({30'h0, pwr, pe}, 32'h3);
    pins_to(5'h07);
    chk({30'h0, pe, alm}, 32'h2);
    pins_to(5'h05);
    chk({30'h0, pwr, alm}, 32'h1);
    pins_to(5'h01);
    chk({31'h0, alm}, 32'h0);
    wr_reg(servo_limit_pkg::ADDR_CTRL, 32'h2);
    pins_to(5'h05);
    chk({31'h0, alm}, 32'h1);
  endtask
  task automatic t_supply;
    pins_to(5'h0b);
    chk({31'h0, pwr}, 32'h1);
    pins_to(5'h0a);
    chk({31'h0, pwr}, 32'h0);
    rd_chk(servo_limit_pkg::ADDR_STATE, 32'h32);
    pins_to(5'h0b);
    chk({31'h0, pwr}, 32'h1);
    pins_to(5'h02);
    pins_to(5'h03);
    chk({31'h0, pwr}, 32'h0);
  endtask
  task automatic t_comm;
    @(posedge clk);
    mmax <= 20'sh00bb8;
    cdone <= 1'b1;
    @(posedge clk);
    cdone <= 1'b0;
    rd_chk(servo_limit_pkg::ADDR_OVR_POS, 32'hbb8);
    rd_chk(8'h2c, -32'sh0bb8);
    rd_chk(servo_limit_pkg::ADDR_STATUS, 32'h6);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    t_reset;
    t_select;
    t_fault;
    t_servo;
    t_supply;
    t_comm;
    test_done;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    test_done;
  end
endmodule
`default_nettype wire
